// ---- logic/current_adc_backend.sv ----
// Decimation, offset/gain calibration and frame hand-off for the current channels
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
// What this block does
// R1 - Software picks each channel's decimation ratio with a three-bit field, powers of two from 64 to 8192.
// R2 - Each ratio setting yields one output word per ratio modulator cycles.
// R3 - The word rate is counted in modulator cycles so it scales with the modulator frequency.
// R4 - The offset is subtracted from the filtered result before the gain factor multiplies it.
// R5 - The product is rounded to 24 bits and clipped to the full-scale codes.
// R6 - The 24-bit two's-complement offset is split over an upper and a lower register.
// R7 - A positive offset lowers the output, all ones raises it by one code.
// R8 - The gain factor is one plus the signed gain value over 65536, from 0.5 to about 1.5.
// R9 - The host rewrites offset and gain after every power-up or reset.
// R10 - The host calibrates offset by zeroing the corrections, shorting inputs and writing the average.
// R11 - The host uses a reference below full scale for gain calibration.
// R12 - Each channel result goes into every frame, except that register read data takes channel 0's slot.
// R13 - Results are 24-bit two's complement, one code being full scale over 2^23.
// R14 - Beyond full scale the output saturates at 7FFFFF or 800000.
// R15 - The modulator clock is the main clock divided by two with even duty.
// R16 - Offset and gain corrections reset to zero so an uncalibrated channel passes data unchanged.
// R17 - Full precision is kept until the final rounding and clipping; the decimator drops bits below RAW_LSB for ratios above 128.
module current_adc_backend
  import current_adc_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Modulator bitstreams from the analog front end, and the modulator clock toward it
  input wire logic [NUM_CH-1:0] i_mod_bit,
  output logic o_mod_clk,
  // Analog input selection per channel
  output logic [SEL_W-1:0] o_current_input_select_0,
  output logic [SEL_W-1:0] o_current_input_select_1,
  // Register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  // Serial frame hand-off
  input wire logic i_frame_start,
  input wire logic i_frame_reg_resp,
  input wire logic [RES_W-1:0] i_frame_reg_word,
  output logic [RES_W-1:0] o_frame_word_0,
  output logic [RES_W-1:0] o_frame_word_1,
  output logic o_frame_valid
);
  logic mod_phase_r;
  logic mod_en;
  logic [NUM_CH-1:0] sync1_r, sync2_r;
  logic [RATIO_W-1:0] decimation_ratio_sel_r [NUM_CH];
  logic [OFS_W-1:0] current_offset_corr_r [NUM_CH];
  logic [GAIN_W-1:0] current_gain_corr_r [NUM_CH];
  logic [SEL_W-1:0] current_input_select_r [NUM_CH];
  logic [RAW_W-1:0] raw [NUM_CH];
  logic [NUM_CH-1:0] raw_valid;
  logic signed [DIFF_W-1:0] diff_r [NUM_CH];
  logic signed [PROD_W-1:0] prod_r [NUM_CH];
  logic [RES_W-1:0] result_r [NUM_CH];
  logic [NUM_CH-1:0] v1_r, v2_r, v3_r;
  logic [NUM_CH-1:0] ready_r, clip_r;
  logic [NUM_CH-1:0] clip_now;
  logic [NUM_CH-1:0] wr_ch, rd_ch;
  logic [4:0] reg_sel;
  logic [DATA_W-1:0] rd_mux;
  logic [RES_W-1:0] frame0_nxt;

  // Modulator clock enable: one pulse every MOD_DIV main clocks
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      mod_phase_r <= 1'b0;
    end else begin
      mod_phase_r <= ~mod_phase_r; // R15
    end
  end
  // Square wave toward the modulator, 50 % duty by construction
  assign o_mod_clk = mod_phase_r; // R15
  assign mod_en = mod_phase_r; // R3

  // Bitstreams come from another domain, so two flops first
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= i_mod_bit;
      sync2_r <= sync1_r;
    end
  end

  assign reg_sel = i_addr[4:0];

  generate
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
      logic signed [GFAC_W-1:0] gfac;
      logic signed [PROD_W-1:0] rounded;
      logic signed [PROD_W-1:0] pos_lim, neg_lim;

      assign wr_ch[ch] = i_wr && (i_addr[CH_BIT] == 1'(ch)) && (i_addr[ADDR_W-1:CH_BIT+1] == '0);
      assign rd_ch[ch] = i_rd && (i_addr[CH_BIT] == 1'(ch)) && (i_addr[ADDR_W-1:CH_BIT+1] == '0);

      // Configuration registers; volatile, cleared on reset
      always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
          decimation_ratio_sel_r[ch] <= RATIO_RST;
          current_offset_corr_r[ch] <= OFS_RST; // R16
          current_gain_corr_r[ch] <= GAIN_RST; // R16
          current_input_select_r[ch] <= SEL_RST;
        end else if (wr_ch[ch]) begin
          case (reg_sel)
            REG_RATIO: begin
              decimation_ratio_sel_r[ch] <= i_wdata[RATIO_W-1:0]; // R1
            end
            REG_OFS_UPPER: begin
              current_offset_corr_r[ch][OFS_W-1:OFS_SPLIT] <= i_wdata[OFS_W-OFS_SPLIT-1:0]; // R6
            end
            REG_OFS_LOWER: begin
              current_offset_corr_r[ch][OFS_SPLIT-1:0] <= i_wdata[OFS_SPLIT-1:0]; // R6
            end
            REG_GAIN: begin
              current_gain_corr_r[ch] <= i_wdata[GAIN_W-1:0];
            end
            REG_INSEL: begin
              current_input_select_r[ch] <= i_wdata[SEL_W-1:0];
            end
            default: begin
            end
          endcase
        end
      end

      sinc3_decimator u_dec (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_mod_en(mod_en),
        .i_bit(sync2_r[ch]),
        .i_ratio_sel(decimation_ratio_sel_r[ch]), // R2
        .o_raw(raw[ch]),
        .o_valid(raw_valid[ch])
      );

      // Gain factor 1 + g/65536 held as 18-bit signed fraction
      assign gfac = $signed(GAIN_ONE) + $signed({{2{current_gain_corr_r[ch][GAIN_W-1]}}, current_gain_corr_r[ch]}); // R8
      // Round half up then drop the gain fraction bits
      assign rounded = (prod_r[ch] + $signed(ROUND_HALF)) >>> GAIN_FRAC; // R5
      assign pos_lim = PROD_W'($signed(POS_FS));
      assign neg_lim = PROD_W'($signed(NEG_FS));
      assign clip_now[ch] = (rounded > pos_lim) || (rounded < neg_lim);

      // Three-stage pipeline: subtract, multiply, round and clip
      always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
          diff_r[ch] <= '0;
          prod_r[ch] <= '0;
          result_r[ch] <= '0;
        end else begin
          if (raw_valid[ch]) begin
            // Raw keeps one headroom bit so +FS of the filter is not lost early
            diff_r[ch] <= $signed({raw[ch][RAW_W-1], raw[ch]})
                          - $signed({{(DIFF_W-OFS_W){current_offset_corr_r[ch][OFS_W-1]}}, current_offset_corr_r[ch]}); // R4 R7 R17
          end
          if (v1_r[ch]) begin
            prod_r[ch] <= diff_r[ch] * gfac; // R4 R17
          end
          if (v2_r[ch]) begin
            if (rounded > pos_lim) begin
              result_r[ch] <= POS_FS; // R14
            end else if (rounded < neg_lim) begin
              result_r[ch] <= NEG_FS; // R14
            end else begin
              result_r[ch] <= rounded[RES_W-1:0]; // R5 R13
            end
          end
        end
      end

      // Stage valids
      always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
          v1_r[ch] <= 1'b0;
          v2_r[ch] <= 1'b0;
          v3_r[ch] <= 1'b0;
        end else begin
          v1_r[ch] <= raw_valid[ch];
          v2_r[ch] <= v1_r[ch];
          v3_r[ch] <= v2_r[ch];
        end
      end

      // Sticky flags: a new event in the clearing read wins
      always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
          ready_r[ch] <= 1'b0;
          clip_r[ch] <= 1'b0;
        end else begin
          if (v3_r[ch]) begin
            ready_r[ch] <= 1'b1;
          end else if (rd_ch[ch] && reg_sel == REG_RESULT) begin
            ready_r[ch] <= 1'b0;
          end
          if (v2_r[ch] && clip_now[ch]) begin
            clip_r[ch] <= 1'b1;
          end else if (rd_ch[ch] && reg_sel == REG_STATUS) begin
            clip_r[ch] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign o_current_input_select_0 = current_input_select_r[0];
  assign o_current_input_select_1 = current_input_select_r[1];

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    rd_mux = '0;
    if (i_addr[ADDR_W-1:CH_BIT+1] == '0) begin
      case (reg_sel)
        REG_RATIO: begin
          rd_mux = DATA_W'(decimation_ratio_sel_r[i_addr[CH_BIT]]);
        end
        REG_OFS_UPPER: begin
          rd_mux = DATA_W'(current_offset_corr_r[i_addr[CH_BIT]][OFS_W-1:OFS_SPLIT]);
        end
        REG_OFS_LOWER: begin
          rd_mux = DATA_W'(current_offset_corr_r[i_addr[CH_BIT]][OFS_SPLIT-1:0]);
        end
        REG_GAIN: begin
          rd_mux = DATA_W'(current_gain_corr_r[i_addr[CH_BIT]]);
        end
        REG_RESULT: begin
          rd_mux = DATA_W'(result_r[i_addr[CH_BIT]]);
        end
        REG_STATUS: begin
          rd_mux[ST_READY] = ready_r[i_addr[CH_BIT]];
          rd_mux[ST_CLIP] = clip_r[i_addr[CH_BIT]];
        end
        REG_INSEL: begin
          rd_mux = DATA_W'(current_input_select_r[i_addr[CH_BIT]]);
        end
        default: begin
          rd_mux = '0;
        end
      endcase
    end
  end

  // Read data stand for exactly the cycle after the strobe
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      o_rdata <= rd_mux;
    end else begin
      o_rdata <= '0;
    end
  end

  // Register read response displaces channel 0's slot only
  assign frame0_nxt = i_frame_reg_resp ? i_frame_reg_word : result_r[0]; // R12

  // Frame words are snapped at frame start so they hold steady while shifting
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_frame_word_0 <= '0;
      o_frame_word_1 <= '0;
      o_frame_valid <= 1'b0;
    end else begin
      o_frame_valid <= i_frame_start;
      if (i_frame_start) begin
        o_frame_word_0 <= frame0_nxt; // R12
        o_frame_word_1 <= result_r[1]; // R12
      end
    end
  end
endmodule

// ---- logic/current_adc_pkg.sv ----
// Shared constants for the current channel decimation and calibration back end
package current_adc_pkg;
  // Channel and datapath widths
  localparam int NUM_CH = 2;
  localparam int RATIO_W = 3;
  localparam int SEL_W = 2;
  localparam int RES_W = 24;
  localparam int OFS_W = 24;
  localparam int GAIN_W = 16;
  localparam int RAW_W = 26;
  localparam int ACC_W = 42;
  localparam int CNT_W = 13;
  localparam int DIFF_W = RAW_W + 1;
  localparam int GFAC_W = GAIN_W + 2;
  localparam int PROD_W = DIFF_W + GFAC_W;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Oversampling ratio: 2^(MIN_LOG2 + sel), 64 .. 8192
  localparam int OSR_MIN_LOG2 = 6;
  localparam int OSR_MAX_LOG2 = 13;
  // Sinc3 full-scale gain is OVERSAMPLING_RATIO^3; normalise to 2^FS_LOG2
  localparam int FS_LOG2 = 39;
  localparam int RAW_LSB = 16;
  localparam int SETTLE_WORDS = 3;

  // Modulator clock is main clock divided by two
  localparam int MOD_DIV = 2;
  localparam real MCLK_MHZ = 100.0;
  localparam real MCLK_PERIOD_NS = 1000.0 / MCLK_MHZ;

  // Calibration constants
  localparam logic [GFAC_W-1:0] GAIN_ONE = 18'h10000;
  localparam logic [PROD_W-1:0] ROUND_HALF = 45'h000000008000;
  localparam int GAIN_FRAC = 16;
  localparam logic [RES_W-1:0] POS_FS = 24'h7FFFFF;
  localparam logic [RES_W-1:0] NEG_FS = 24'h800000;

  // Reset values: uncalibrated channel passes data unchanged
  localparam logic [OFS_W-1:0] OFS_RST = 24'h000000;
  localparam logic [GAIN_W-1:0] GAIN_RST = 16'h0000;
  localparam logic [RATIO_W-1:0] RATIO_RST = 3'h0;
  localparam logic [SEL_W-1:0] SEL_RST = 2'h0;
  localparam logic [SEL_W-1:0] SEL_SHORT = 2'h2;

  // Register map: channel chosen by address bit CH_BIT, register by low bits
  localparam int CH_BIT = 5;
  localparam logic [4:0] REG_RATIO = 5'h00;
  localparam logic [4:0] REG_OFS_UPPER = 5'h04;
  localparam logic [4:0] REG_OFS_LOWER = 5'h08;
  localparam logic [4:0] REG_GAIN = 5'h0C;
  localparam logic [4:0] REG_RESULT = 5'h10;
  localparam logic [4:0] REG_STATUS = 5'h14;
  localparam logic [4:0] REG_INSEL = 5'h18;
  localparam int OFS_SPLIT = 8;
  localparam int ST_READY = 0;
  localparam int ST_CLIP = 1;
endpackage

// ---- logic/sinc3_decimator.sv ----
// Sinc3 decimator for one modulator bitstream with programmable ratio
`timescale 1ns/1ps
module sinc3_decimator
  import current_adc_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Modulator side
  input wire logic i_mod_en,
  input wire logic i_bit,
  input wire logic [RATIO_W-1:0] i_ratio_sel,
  // Filtered output
  output logic [RAW_W-1:0] o_raw,
  output logic o_valid
);
  logic signed [ACC_W-1:0] int1_r, int2_r, int3_r;
  logic signed [ACC_W-1:0] d1_r, d2_r, d3_r;
  logic signed [ACC_W-1:0] c1, c2, c3, norm;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] last_cnt;
  logic [RATIO_W-1:0] sel_r;
  logic [1:0] settle_r;
  logic dump;
  logic [5:0] shamt;

  // Counter end is ratio - 1
  assign last_cnt = CNT_W'((32'd1 << (OSR_MIN_LOG2 + int'(i_ratio_sel))) - 32'd1);
  assign dump = i_mod_en && (cnt_r == last_cnt);
  assign c1 = int3_r - d1_r;
  assign c2 = c1 - d2_r;
  assign c3 = c2 - d3_r;
  assign shamt = 6'(FS_LOG2 - 3 * (OSR_MIN_LOG2 + int'(i_ratio_sel)));
  assign norm = c3 <<< shamt;

  // Integrators advance once per modulator cycle; wraparound is harmless
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      int1_r <= '0;
      int2_r <= '0;
      int3_r <= '0;
    end else if (i_mod_en) begin
      int1_r <= int1_r + (i_bit ? ACC_W'(1) : -ACC_W'(1));
      int2_r <= int2_r + int1_r;
      int3_r <= int3_r + int2_r;
    end
  end

  // Ratio counter restarts when the ratio changes
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_r <= '0;
      sel_r <= RATIO_RST;
    end else begin
      sel_r <= i_ratio_sel;
      if (sel_r != i_ratio_sel) begin
        cnt_r <= '0;
      end else if (dump) begin
        cnt_r <= '0;
      end else if (i_mod_en) begin
        cnt_r <= cnt_r + CNT_W'(1);
      end
    end
  end

  // Combs at output rate; first words after a ratio change are unsettled
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      d1_r <= '0;
      d2_r <= '0;
      d3_r <= '0;
      o_raw <= '0;
      o_valid <= 1'b0;
      settle_r <= '0;
    end else begin
      o_valid <= 1'b0;
      if (sel_r != i_ratio_sel) begin
        settle_r <= '0;
      end else if (dump) begin
        d1_r <= int3_r;
        d2_r <= c1;
        d3_r <= c2;
        o_raw <= norm[ACC_W-1:RAW_LSB];
        if (settle_r == 2'(SETTLE_WORDS)) begin
          o_valid <= 1'b1;
        end else begin
          settle_r <= settle_r + 2'd1;
        end
      end
    end
  end
endmodule

// ---- verif/current_adc_backend_asserts.sv ----
// Port-level assertions for the current channel back end
`timescale 1ns/1ps
module current_adc_backend_asserts
  import current_adc_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Modulator side
  input wire logic [NUM_CH-1:0] i_mod_bit,
  input wire logic o_mod_clk,
  input wire logic [SEL_W-1:0] o_current_input_select_0,
  input wire logic [SEL_W-1:0] o_current_input_select_1,
  // Register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  // Frame hand-off
  input wire logic i_frame_start,
  input wire logic i_frame_reg_resp,
  input wire logic [RES_W-1:0] i_frame_reg_word,
  input wire logic [RES_W-1:0] o_frame_word_0,
  input wire logic [RES_W-1:0] o_frame_word_1,
  input wire logic o_frame_valid
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);

  // Write, one idle cycle, then a read of the same register
  sequence s_wr_rd(logic [7:0] a);
    (i_wr && i_addr == a) ##2 (i_rd && i_addr == a);
  endsequence

  property p_readback(logic [7:0] a, logic [31:0] m);
    s_wr_rd(a) |=> o_rdata == ($past(i_wdata, 3) & m);
  endproperty

  // First edge after release still sees the reset level
  a_modclk_toggle: assert property ($past(i_nrst) |-> o_mod_clk != $past(o_mod_clk))
    else $error("modulator clock did not toggle");
  a_frame_valid_pulse: assert property (o_frame_valid == $past(i_frame_start))
    else $error("frame valid not one cycle after frame start");
  a_frame_resp_word: assert property (i_frame_start && i_frame_reg_resp |=> o_frame_word_0 == $past(i_frame_reg_word))
    else $error("register response word missing from frame");
  a_frame_word_hold: assert property (!i_frame_start |=> $stable(o_frame_word_0) && $stable(o_frame_word_1))
    else $error("frame words changed without frame start");
  a_ratio_readback: assert property (p_readback(8'h00, 32'h00000007))
    else $error("ratio select readback wrong");
  a_ofs_upper_rb: assert property (p_readback(8'h04, 32'h0000FFFF))
    else $error("offset upper readback wrong");
  a_ofs_lower_rb: assert property (p_readback(8'h08, 32'h000000FF))
    else $error("offset lower readback wrong");
  a_gain_readback: assert property (p_readback(8'h0C, 32'h0000FFFF))
    else $error("gain readback wrong");
  a_result_width: assert property (i_rd && i_addr == 8'h10 |=> o_rdata[31:24] == 8'h00)
    else $error("result wider than 24 bits");
endmodule

bind current_adc_backend current_adc_backend_asserts chk_u (.i_mclk, .i_nrst, .i_mod_bit, .o_mod_clk,
  .o_current_input_select_0, .o_current_input_select_1, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
  .i_frame_start, .i_frame_reg_resp, .i_frame_reg_word, .o_frame_word_0, .o_frame_word_1, .o_frame_valid);

// ---- verif/mod_source.sv ----
// Modulator stand-in driving one bit per channel each modulator clock
`timescale 1ns/1ps
module mod_source
  import current_adc_pkg::*;
(
  // Modulator clock and reset from the block
  input wire logic i_mod_clk,
  input wire logic i_nrst,
  // Requested level and input selection per channel
  input wire logic [NUM_CH-1:0] i_level,
  input wire logic [SEL_W-1:0] i_sel_0,
  input wire logic [SEL_W-1:0] i_sel_1,
  // Bitstreams toward the block
  output logic [NUM_CH-1:0] o_bits
);
  // Shorted input settles near zero, so the stream alternates
  always_ff @(posedge i_mod_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_bits <= '0;
    end else begin
      o_bits[0] <= (i_sel_0 == SEL_SHORT) ? ~o_bits[0] : i_level[0];
      o_bits[1] <= (i_sel_1 == SEL_SHORT) ? ~o_bits[1] : i_level[1];
    end
  end
endmodule

// ---- verif/tb.sv ----
// Self-checking bench for the current channel back end
`timescale 1ns/1ps
module tb;
  import current_adc_pkg::*;
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [DATA_W-1:0] i_wdata = '0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_frame_start = 1'b0;
  logic i_frame_reg_resp = 1'b0;
  logic [RES_W-1:0] i_frame_reg_word = '0;
  logic [NUM_CH-1:0] level = '1;
  logic [NUM_CH-1:0] i_mod_bit;
  logic o_mod_clk;
  logic [SEL_W-1:0] o_current_input_select_0;
  logic [SEL_W-1:0] o_current_input_select_1;
  logic [DATA_W-1:0] o_rdata;
  logic [RES_W-1:0] o_frame_word_0;
  logic [RES_W-1:0] o_frame_word_1;
  logic o_frame_valid;
  logic [31:0] q;
  int mismatches = 0;
  int n_checks = 0;
  int cyc_n = 0;
  // Raw stream is +/- full scale; fields: level, offset, gain, expected word
  localparam logic [64:0] CAL_TAB [9] = '{
    {1'b1, 24'h000000, 16'h0000, 24'h7FFFFF},
    {1'b1, 24'h000010, 16'h0000, 24'h7FFFF0},
    {1'b0, 24'hFFFFFF, 16'h0000, 24'h800001},
    {1'b0, 24'h000001, 16'h0000, 24'h800000},
    {1'b1, 24'h000000, 16'h8000, 24'h400000},
    {1'b1, 24'h400000, 16'h7FFF, 24'h5FFFC0},
    {1'b0, 24'h000000, 16'hFFFF, 24'h800080},
    {1'b1, 24'h7FFFFF, 16'h8000, 24'h000001},
    {1'b0, 24'h7FFFFF, 16'h8000, 24'h800001}
  };

  always #5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) cyc_n <= cyc_n + 1;

  current_adc_backend dut_u (.i_mclk, .i_nrst, .i_mod_bit, .o_mod_clk, .o_current_input_select_0,
    .o_current_input_select_1, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_frame_start,
    .i_frame_reg_resp, .i_frame_reg_word, .o_frame_word_0, .o_frame_word_1, .o_frame_valid);
  mod_source src_u (.i_mod_clk(o_mod_clk), .i_nrst, .i_level(level), .i_sel_0(o_current_input_select_0),
    .i_sel_1(o_current_input_select_1), .o_bits(i_mod_bit));

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  // One access, entered at a rising edge; read data taken mid-cycle after it
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_wr <= w;
    i_rd <= !w;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    @(negedge i_mclk);
    q = o_rdata;
    @(posedge i_mclk);
  endtask

  task automatic wrb(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    bus(1'b0, a, 32'h0);
    chk("register readback", d, q);
  endtask

  // Polls ready at a fixed two-cycle pace so word spacing is measured exactly
  task automatic wready(input int oversampling_ratio);
    int k;
    k = 0;
    q = 32'h0;
    while (q[ST_READY] !== 1'b1) begin
      bus(1'b0, 8'h14, 32'h0);
      k++;
      if (k > 8 * oversampling_ratio) begin
        mismatches++;
        $display("[FAIL] ready flag expected 1 seen timeout");
        test_done();
      end
    end
  endtask

  task automatic t_reset;
    i_nrst <= 1'b0;
    repeat (5) @(posedge i_mclk);
    i_nrst <= 1'b1;
    @(posedge i_mclk);
    bus(1'b1, 8'h40, 32'hFFFFFFFF);
    for (int a = 0; a < 64; a += 4) begin
      bus(1'b0, 8'(a), 32'h0);
      chk("reset value", 32'h0, q);
    end
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped read", 32'h0, q);
  endtask

  task automatic t_rate;
    int t [3];
    for (int s = 0; s < 8; s++) begin
      wrb(8'h00, 32'(s));
      if (s < 6) begin
        for (int k = 0; k < 3; k++) begin
          wready(64 << s);
          t[k] = cyc_n;
          bus(1'b0, 8'h10, 32'h0);
        end
        chk("word period", 32'(MOD_DIV * (64 << s)), 32'(t[2] - t[1]));
      end
    end
  endtask

  task automatic t_cal;
    logic [64:0] e;
    wrb(8'h18, 32'(SEL_SHORT));
    wrb(8'h00, 32'h0);
    chk("input select", 32'(SEL_SHORT), 32'(o_current_input_select_0));
    for (int c = 0; c < 2; c++) begin
      wrb(8'(c * 32 + 24), 32'h0);
      wrb(8'(c * 32), 32'h0);
    end
    chk("input select ch1", 32'(SEL_RST), 32'(o_current_input_select_1));
    foreach (CAL_TAB[i]) begin
      e = CAL_TAB[i];
      level <= {2{e[64]}};
      for (int c = 0; c < 2; c++) begin
        wrb(8'(c * 32 + 4), 32'(e[63:48]));
        wrb(8'(c * 32 + 8), 32'(e[47:40]));
        wrb(8'(c * 32 + 12), 32'(e[39:24]));
      end
      // Filter needs several words to settle on the new level
      for (int k = 0; k < 6; k++) begin
        wready(64);
        bus(1'b0, 8'h10, 32'h0);
      end
      chk("result ch0", {8'h00, e[23:0]}, q);
      bus(1'b0, 8'h30, 32'h0);
      chk("result ch1", {8'h00, e[23:0]}, q);
      // Clear sticky clip and ready, then judge one settled word
      bus(1'b0, 8'h34, 32'h0);
      bus(1'b0, 8'h10, 32'h0);
      wready(64);
      bus(1'b0, 8'h34, 32'h0);
      chk("clip flag ch1", 32'(i == 0 || i == 3), 32'(q[ST_CLIP]));
      i_frame_reg_resp <= i[0];
      i_frame_reg_word <= ~e[23:0];
      i_frame_start <= 1'b1;
      @(posedge i_mclk);
      i_frame_start <= 1'b0;
      @(negedge i_mclk);
      chk("frame valid", 32'h1, 32'(o_frame_valid));
      chk("frame word 0", 32'(i[0] ? i_frame_reg_word : e[23:0]), 32'(o_frame_word_0));
      chk("frame word 1", 32'(e[23:0]), 32'(o_frame_word_1));
      @(posedge i_mclk);
    end
  endtask

  initial begin
    t_reset();
    t_rate();
    t_cal();
    t_reset();
    test_done();
  end
endmodule
